// ==== rtl/psl_regs.v ====
// PHY status register bank: link-drop cause latch, PHY status word and
// the clock-disable control bit, reached over APB.
// Assumes PHY status sources are asynchronous levels; clear strobes from
// the neighbouring register blocks and the drop enables are on mclk.
`timescale 1ns/1ps
`include "psl_map.vh"

module psl_regs #(
    parameter                ADDR_W = 12
) (
    input  wire              mclk,
    input  wire              rstn,
    input  wire              ce,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output wire [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              link_up,
    input  wire              speed_10,
    input  wire              full_duplex,
    input  wire              loopback_on,
    input  wire              an_done,
    input  wire              jabber,
    input  wire              remote_fault,
    input  wire              irq_pending,
    input  wire              page_rcvd,
    input  wire              desc_lock,
    input  wire              signal_det,
    input  wire              false_carrier,
    input  wire              polarity_inv,
    input  wire              rx_error,
    input  wire              mdix_swap,
    input  wire              energy_loss,
    input  wire              snr_low,
    input  wire              three_level_line_code_error,
    input  wire              desc_sync_loss,
    input  wire              power_down,
    input  wire [4:0]        drop_en,
    input  wire              rd_rx_err_cnt,
    input  wire              rd_ten_meg_status,
    input  wire              rd_false_carrier,
    input  wire              rd_autoneg_exp,
    input  wire              rd_int_src,
    input  wire              rd_basic_status,
    output wire              link_drop,
    output wire              clk_disable
);

////////////////////////////////////////////////////////////////////////////
// Constants and functions

localparam integer WIN_CYC_I = (`PSL_WIN_NS * 1000) / `PSL_CLK_PS;
localparam [11:0]  WIN_LAST  = WIN_CYC_I[11:0] - 12'h001;
localparam [5:0]   RX_THR    = `PSL_RXERR_MAX;
localparam [5:0]   EV_THR    = `PSL_EVT_MAX;

function [ADDR_W-1:0] addr_of;
    input [7:0] idx;
    begin
        addr_of = {{(ADDR_W-10){1'b0}}, idx, 2'b00};
    end
endfunction

// Saturating event count within the window
function [5:0] evt_cnt;
    input [5:0] cnt;
    input       evt;
    input       restart;
    input [5:0] thr;
    begin
        if (restart)
            evt_cnt = {5'h00, evt};
        else if (cnt == thr)
            evt_cnt = cnt;
        else
            evt_cnt = cnt + {5'h00, evt};
    end
endfunction

// Latch-high update; set wins over clear
function lh;
    input cur;
    input set;
    input clr;
    begin
        lh = (cur & ~clr) | set;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Input synchronisation

wire [`PSL_S_W-1:0] raw;
wire [`PSL_S_W-1:0] st;

assign raw = {power_down, desc_sync_loss, three_level_line_code_error, snr_low, energy_loss,
              mdix_swap, rx_error, polarity_inv, false_carrier, signal_det,
              desc_lock, page_rcvd, irq_pending, remote_fault, jabber,
              an_done, loopback_on, full_duplex, speed_10, link_up};

psl_sync #(
    .W       (`PSL_S_W),
    .RST_VAL (`PSL_SYNC_RST)
) u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .ce   (ce),
    .din  (raw),
    .dout (st)
);

////////////////////////////////////////////////////////////////////////////
// APB decode

wire [31:0] rd_mux;
wire        sel_ldrop;
wire        sel_stat;
wire        sel_ctrl;
wire        mapped;
wire        setup;
wire        access;
wire        rd_fire;
wire        wr_fire;
reg  [31:0] prdata_reg;

assign sel_ldrop = (paddr == addr_of(`PSL_IDX_LDROP));
assign sel_stat  = (paddr == addr_of(`PSL_IDX_STAT));
assign sel_ctrl  = (paddr == addr_of(`PSL_IDX_CTRL));
assign mapped    = sel_ldrop | sel_stat | sel_ctrl;
assign setup     = psel & ~penable;
assign access    = psel & penable & ce;
assign rd_fire   = access & ~pwrite;
assign wr_fire   = access & pwrite;
assign pready    = ce;
assign pslverr   = psel & penable & ~mapped;
assign prdata    = prdata_reg;

////////////////////////////////////////////////////////////////////////////
// Fast link-drop detection

reg  [11:0] win_reg;
reg  [5:0]  rx_cnt_reg;
reg  [5:0]  three_level_line_code_cnt_reg;
reg  [5:0]  snr_cnt_reg;
reg  [4:0]  prev_reg;
reg         link_drop_reg;
wire        win_end;
wire [4:0]  cur_ev;
wire [4:0]  edge_ev;
wire [5:0]  rx_cnt_next;
wire [5:0]  three_level_line_code_cnt_next;
wire [5:0]  snr_cnt_next;
wire [4:0]  trig;
wire [4:0]  hit;

assign win_end = (win_reg == WIN_LAST);
assign cur_ev  = {st[`PSL_S_DSYNC], st[`PSL_B_RXERR], st[`PSL_S_THREE_LEVEL_LINE_CODE],
                  st[`PSL_S_SNR], st[`PSL_S_ENERGY]};
assign edge_ev = cur_ev & ~prev_reg;

assign rx_cnt_next   = evt_cnt(rx_cnt_reg, edge_ev[3], win_end, RX_THR);
assign three_level_line_code_cnt_next = evt_cnt(three_level_line_code_cnt_reg, edge_ev[2], win_end, EV_THR);
assign snr_cnt_next  = evt_cnt(snr_cnt_reg, edge_ev[1], win_end, EV_THR);

assign trig = {edge_ev[4],
               (rx_cnt_next == RX_THR) & (rx_cnt_reg != RX_THR),
               (three_level_line_code_cnt_next == EV_THR) & (three_level_line_code_cnt_reg != EV_THR),
               (snr_cnt_next == EV_THR) & (snr_cnt_reg != EV_THR),
               edge_ev[0]};
assign hit  = trig & drop_en;

assign link_drop = link_drop_reg;

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        win_reg       <= 12'h000;
        rx_cnt_reg    <= 6'h00;
        three_level_line_code_cnt_reg  <= 6'h00;
        snr_cnt_reg   <= 6'h00;
        prev_reg      <= 5'h00;
        link_drop_reg <= 1'b0;
    end else if (ce) begin
        win_reg       <= win_end ? 12'h000 : win_reg + 12'h001;
        rx_cnt_reg    <= rx_cnt_next;
        three_level_line_code_cnt_reg  <= three_level_line_code_cnt_next;
        snr_cnt_reg   <= snr_cnt_next;
        prev_reg      <= cur_ev;
        link_drop_reg <= |hit;
    end
end

////////////////////////////////////////////////////////////////////////////
// Latched status bits

reg  [4:0]  cause_reg;
reg         rxerr_reg;
reg         pol_reg;
reg         fcarr_reg;
reg         sigdet_reg;
reg         dlock_reg;
reg         page_reg;
reg         irq_reg;
reg         rfault_reg;
reg         clkdis_reg;
wire [4:0]  cause_clr;
wire        stat_rd;
wire [15:0] stat_word;
wire [15:0] ldrop_word;
wire [15:0] ctrl_word;

// Clear only what the read actually reported
assign cause_clr = (rd_fire & sel_ldrop) ?
                   prdata_reg[`PSL_CAUSE_MSB:`PSL_CAUSE_LSB] : 5'h00;
assign stat_rd   = rd_fire & sel_stat;

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        cause_reg  <= 5'h00;
        rxerr_reg  <= 1'b0;
        pol_reg    <= 1'b0;
        fcarr_reg  <= 1'b0;
        sigdet_reg <= 1'b0;
        dlock_reg  <= 1'b0;
        page_reg   <= 1'b0;
        irq_reg    <= 1'b0;
        rfault_reg <= 1'b0;
        clkdis_reg <= `PSL_CTRL_RST;
    end else if (ce) begin
        cause_reg  <= (cause_reg & ~cause_clr) | hit;
        rxerr_reg  <= lh(rxerr_reg, st[`PSL_B_RXERR], rd_rx_err_cnt);
        pol_reg    <= lh(pol_reg, st[`PSL_B_POL], rd_ten_meg_status);
        fcarr_reg  <= lh(fcarr_reg, st[`PSL_B_FCARR], rd_false_carrier);
        page_reg   <= lh(page_reg, st[`PSL_B_PAGE], rd_autoneg_exp);
        irq_reg    <= lh(irq_reg, st[`PSL_B_IRQ], rd_int_src);
        rfault_reg <= lh(rfault_reg, st[`PSL_B_RFAULT], rd_basic_status);
        // Latch-low: a read reloads the live level
        sigdet_reg <= stat_rd ? st[`PSL_B_SIGDET]
                              : (sigdet_reg & st[`PSL_B_SIGDET]);
        dlock_reg  <= stat_rd ? st[`PSL_B_DLOCK]
                              : (dlock_reg & st[`PSL_B_DLOCK]);
        if (!st[`PSL_S_PWRDN])
            clkdis_reg <= 1'b0;
        else if (wr_fire & sel_ctrl)
            clkdis_reg <= pwdata[`PSL_B_CLKDIS];
    end
end

assign clk_disable = clkdis_reg;

////////////////////////////////////////////////////////////////////////////
// Read words

assign ldrop_word = {7'h00, cause_reg, 4'h0};
assign stat_word  = {1'b0,
                     st[`PSL_B_MDIX],
                     rxerr_reg,
                     pol_reg,
                     fcarr_reg,
                     sigdet_reg,
                     dlock_reg,
                     page_reg,
                     irq_reg,
                     rfault_reg,
                     st[`PSL_B_JABBER],
                     st[`PSL_B_ANDONE],
                     st[`PSL_B_LOOP],
                     st[`PSL_B_DUPLEX],
                     st[`PSL_B_SPEED],
                     st[`PSL_B_LINK]};
assign ctrl_word  = {clkdis_reg, 15'h0000};

assign rd_mux = sel_ldrop ? {16'h0000, ldrop_word} :
                sel_stat  ? {16'h0000, stat_word}  :
                sel_ctrl  ? {16'h0000, ctrl_word}  : 32'h00000000;

// Read data captured in the setup cycle, stable through the access
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        prdata_reg <= 32'h00000000;
    end else if (ce) begin
        if (setup & ~pwrite)
            prdata_reg <= rd_mux;
    end
end

endmodule

// ==== rtl/psl_map.vh ====
// Offsets, field positions, reset values and timing counts of the
// PHY status and link-drop register bank.
// Assumes it is included by bare name from the design files.
`ifndef PSL_MAP_VH
`define PSL_MAP_VH

// Register indices; byte address is four times the index
`define PSL_IDX_LDROP    8'h0F
`define PSL_IDX_STAT     8'h10
`define PSL_IDX_CTRL     8'h11

// Status bit positions, also the positions in the synchronised vector
`define PSL_B_LINK       0
`define PSL_B_SPEED      1
`define PSL_B_DUPLEX     2
`define PSL_B_LOOP       3
`define PSL_B_ANDONE     4
`define PSL_B_JABBER     5
`define PSL_B_RFAULT     6
`define PSL_B_IRQ        7
`define PSL_B_PAGE       8
`define PSL_B_DLOCK      9
`define PSL_B_SIGDET     10
`define PSL_B_FCARR      11
`define PSL_B_POL        12
`define PSL_B_RXERR      13
`define PSL_B_MDIX       14

// Further synchronised inputs
`define PSL_S_ENERGY     15
`define PSL_S_SNR        16
`define PSL_S_THREE_LEVEL_LINE_CODE       17
`define PSL_S_DSYNC      18
`define PSL_S_PWRDN      19
`define PSL_S_W          20
`define PSL_SYNC_RST     20'h00002

// Link-drop cause field, one-hot codes and enable bit order
`define PSL_CAUSE_LSB    4
`define PSL_CAUSE_MSB    8
`define PSL_CAUSE_DSYNC  5'h10
`define PSL_CAUSE_RXERR  5'h08
`define PSL_CAUSE_THREE_LEVEL_LINE_CODE   5'h04
`define PSL_CAUSE_SNR    5'h02
`define PSL_CAUSE_ENERGY 5'h01

// Control register
`define PSL_B_CLKDIS     15
`define PSL_CTRL_RST     1'b0

// Timing
`define PSL_CLK_PS       4000
`define PSL_WIN_NS       10000
`define PSL_RXERR_MAX    6'h20
`define PSL_EVT_MAX      6'h14

`endif

// ==== rtl/psl_sync.v ====
// Three-stage synchroniser with agreement filter for a vector of levels.
// Assumes inputs are asynchronous to mclk; output changes only when the
// second and third stages agree.
`timescale 1ns/1ps

module psl_sync #(
    parameter             W       = 1,
    parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
    input  wire           mclk,
    input  wire           rstn,
    input  wire           ce,
    input  wire [W-1:0]   din,
    output wire [W-1:0]   dout
);

reg  [W-1:0] s1_reg;
reg  [W-1:0] s2_reg;
reg  [W-1:0] s3_reg;
reg  [W-1:0] out_reg;
wire [W-1:0] agree;

assign agree = ~(s2_reg ^ s3_reg);
assign dout  = out_reg;

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        s1_reg  <= RST_VAL;
        s2_reg  <= RST_VAL;
        s3_reg  <= RST_VAL;
        out_reg <= RST_VAL;
    end else if (ce) begin
        s1_reg  <= din;
        s2_reg  <= s1_reg;
        s3_reg  <= s2_reg;
        out_reg <= (agree & s3_reg) | (~agree & out_reg);
    end
end

endmodule

// ==== tb/psl_regs_asserts.sv ====
// Checker for the PHY status register bank: APB map, control bit, drops.
// Assumes it is bound to psl_regs and sees only that module's ports.
`timescale 1ns/1ps
module psl_regs_chk #(
    parameter ADDR_W = 12
) (
    input wire              mclk,
    input wire              rstn,
    input wire              ce,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    input wire [4:0]        drop_en,
    input wire              power_down,
    input wire              link_drop,
    input wire              clk_disable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire acc = psel && penable && pready;
    wire rda = acc && !pwrite;
    wire hit = paddr == 12'h03C || paddr == 12'h040 || paddr == 12'h044;
////////////////////////////////////////
    chk_slverr_map: assert property (
        pslverr == (psel && penable && !hit)) else $error("slave error wrong");
    chk_unmap_zero: assert property (
        rda && pslverr |-> prdata == '0) else $error("unmapped read not zero");
    chk_stat_rsvd: assert property (
        rda && paddr == 12'h040 |-> prdata[31:15] == '0) else $error("status reserved set");
    chk_cause_rsvd: assert property (
        rda && paddr == 12'h03C |-> prdata[31:9] == '0 && prdata[3:0] == '0)
        else $error("cause reserved set");
    chk_ctrl_read: assert property (
        rda && paddr == 12'h044 |-> prdata == {16'h0000, clk_disable, 15'h0000})
        else $error("control read wrong");
    chk_clkdis_rise: assert property (
        $rose(clk_disable) |-> $past(acc && pwrite && paddr == 12'h044 && pwdata[15]))
        else $error("clock disable set without write");
    chk_clkdis_pd: assert property (
        (ce && !power_down) [*8] |-> !clk_disable)
        else $error("clock disable outside power down");
    chk_clkdis_clr: assert property (
        acc && pwrite && paddr == 12'h044 && !pwdata[15] |=> !clk_disable)
        else $error("clock disable not cleared");
    chk_drop_enabled: assert property (
        link_drop |-> |$past(drop_en)) else $error("drop without enable");
endmodule
bind psl_regs psl_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// ==== tb/psl_regs_tb_top.sv ====
// Bench for the PHY status register bank, driven over APB.
// Assumes psl_regs with its checker bound; all ports driven from here.
`timescale 1ns/1ps
module psl_regs_tb_top;
    logic        mclk = 1'b0, rstn = 1'b0, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, q;
    wire  [31:0] prdata;
    wire         pready, pslverr, link_drop, clk_disable;
    logic        link_up = '0, speed_10 = '1, full_duplex = '0, loopback_on = '0;
    logic        an_done = '0, jabber = '0, remote_fault = '0, irq_pending = '0;
    logic        page_rcvd = '0, desc_lock = '0, signal_det = '0, false_carrier = '0;
    logic        polarity_inv = '0, rx_error = '0, mdix_swap = '0, energy_loss = '0;
    logic        snr_low = '0, three_level_line_code_error = '0, desc_sync_loss = '0, power_down = '0;
    logic [4:0]  drop_en = '0;
    logic [5:0]  cp = '0;
    wire         rd_rx_err_cnt = cp[0], rd_ten_meg_status = cp[1], rd_false_carrier = cp[2];
    wire         rd_autoneg_exp = cp[3], rd_int_src = cp[4], rd_basic_status = cp[5];
    int          n_fail = 0, tests_run = 0, drops = 0;
    int          bp[6] = '{13, 12, 11, 8, 7, 6};
    int          ne[5] = '{1, 20, 20, 32, 1};
    logic [31:0] base = 32'h0000463D;

    psl_regs #(.ADDR_W(12)) dut_u (.*);

    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) if (link_drop === 1'b1) drops++;
////////////////////////////////////////
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(q, e);
    endtask
    task automatic src(input int k, input logic v);
        case (k)
            0: energy_loss <= v;
            1: snr_low <= v;
            2: three_level_line_code_error <= v;
            3, 5: rx_error <= v;
            4: desc_sync_loss <= v;
            6: polarity_inv <= v;
            7: false_carrier <= v;
            8: page_rcvd <= v;
            9: irq_pending <= v;
            10: remote_fault <= v;
            11: signal_det <= v;
            default: desc_lock <= v;
        endcase
    endtask
    task automatic pulse(input int k, input logic v);
        @(posedge mclk) src(k, v);
        w(6);
        @(posedge mclk) src(k, !v);
        w(6);
    endtask
    task automatic clr(input int i);
        @(posedge mclk) cp <= 6'h01 << i;
        @(posedge mclk) cp <= '0;
    endtask
    task give_verdict;
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
////////////////////////////////////////
    initial begin
        #400000;
        n_fail++;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        rd(12'h040, 32'h00000002);
        rd(12'h03C, '0);
        rd(12'h048, '0);
        @(posedge mclk);
        {mdix_swap, jabber, an_done, loopback_on, full_duplex, link_up} <= '1;
        {speed_10, signal_det, desc_lock} <= 3'b011;
        w(8);
        apb(1'b0, 12'h040, '0);
        rd(12'h040, base);
        rd(12'h040, base);
        for (int i = 0; i < 2; i++) begin
            pulse(11 + i, 1'b0);
            rd(12'h040, base & ~(32'h00000400 >> i));
            rd(12'h040, base);
        end
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk) src(5 + i, 1'b1);
            w(8);
            rd(12'h040, base | (1 << bp[i]));
            clr(i);
            rd(12'h040, base | (1 << bp[i]));
            @(posedge mclk) src(5 + i, 1'b0);
            w(8);
            rd(12'h040, base | (1 << bp[i]));
            clr(i);
            rd(12'h040, base);
        end
        apb(1'b1, 12'h044, 32'h00008000);
        w(1);
        chk(clk_disable, 1'b0);
        @(posedge mclk) power_down <= 1'b1;
        w(8);
        apb(1'b1, 12'h044, 32'h00008000);
        rd(12'h044, 32'h00008000);
        apb(1'b1, 12'h044, '0);
        rd(12'h044, '0);
        apb(1'b1, 12'h044, 32'h00008000);
        // Clock enable low freezes the bit although power-down ends
        @(posedge mclk) {ce, power_down} <= 2'b00;
        w(8);
        chk(clk_disable, 1'b1);
        @(posedge mclk) ce <= 1'b1;
        w(8);
        chk(clk_disable, 1'b0);
        apb(1'b1, 12'h040, 32'hFFFFFFFF);
        apb(1'b1, 12'h03C, 32'hFFFFFFFF);
        rd(12'h040, base);
        rd(12'h03C, '0);
        for (int k = 0; k < 5; k++) begin
            for (int m = 0; m < 3; m++) begin
                w(2600);
                drops = 0;
                @(posedge mclk) drop_en <= (m == 1) ? 5'h00 : 5'h01 << k;
                repeat (m ? 2 * ne[k] - 1 : ne[k] - 1) pulse(k, 1'b1);
                w(4);
                chk(drops, m == 2);
                rd(12'h03C, m == 2 ? 32'h00000010 << k : '0);
            end
            rd(12'h03C, '0);
        end
        give_verdict;
    end
endmodule
